// [hdl/ocfr_pkg.sv]
// Purpose: Shared constants and helpers for the output current fault response block.
// Assumes: 40 MHz clk_sys; commands arrive already decoded from the serial command bus.
// Notes: Functional notes follow.
// Functional notes
// - Detected fault sets status byte, status word and channel current flag bits.
// - Any current fault pulls the open-drain alert line low.
// - Faults come from the fast supervisor and may need deglitch filtering.
// - Action 00b or 01b: keep running, never clamp current.
// - Action 10b: run for the delay, shut down only if fault persists.
// - Action 11b: shut down at once, or sequence off when tracking; the delay field still deglitches the fault first.
// - After a fault shutdown, restart follows the retry field in bits 5:3.
// - Zero retry field leaves the channel off until the channel is commanded off.
// - Nonzero retry restarts up to global limit; command off or fault stops it.
// - New response settings take effect at the next off-then-on sequence.
// - Delay field 000b adds no deglitch filtering.
// - Delay codes 001b to 111b select 100 us up to 100 ms.
// - Clear faults empties status and releases alert, but keeps channels off.
// - Restart attempts are spaced by the word-wide restart interval.
// - One global attempt limit, the low three bits of the byte-wide count, applies to all retrying channels.

`default_nettype none

package ocfr_pkg;

   // ********************************************************************
   // Sizes and command codes
   // ********************************************************************
   localparam int NUM_CH = 4;
   localparam int DG_CNT_W = 17;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OC_RESP = 8'h47;
   localparam logic [7:0] CMD_UC_RESP = 8'h4C;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_FLAGS = 8'h7B;
   localparam logic [7:0] CMD_RETRY_DELAY = 8'hDB;
   localparam logic [7:0] CMD_RETRY_COUNT = 8'hF7;

   // ********************************************************************
   // Field positions and reset values
   // ********************************************************************
   localparam int ACT_SHUT_BIT = 7;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DLY_MSB = 2;
   localparam int DLY_LSB = 0;
   localparam int CNT_MSB = 2;
   localparam int IOUT_OC_BIT = 7;
   localparam int IOUT_UC_BIT = 4;
   localparam int SB_IOUT_OC_BIT = 4;
   localparam int SB_OTHER_BIT = 0;
   localparam int SW_IOUT_BIT = 14;
   localparam logic [7:0] RST_RESP = 8'h00;
   localparam logic [15:0] RST_RETRY_DELAY = 16'hF320;
   localparam logic [7:0] RST_RETRY_COUNT = 8'h07;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_TICK_NS = 1000;
   localparam int US_TICK_CYC = (T_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_PER_MS = 1000;
   localparam logic [DG_CNT_W-1:0] DG_US_1 = 17'd100;
   localparam logic [DG_CNT_W-1:0] DG_US_2 = 17'd1000;
   localparam logic [DG_CNT_W-1:0] DG_US_3 = 17'd5000;
   localparam logic [DG_CNT_W-1:0] DG_US_4 = 17'd10000;
   localparam logic [DG_CNT_W-1:0] DG_US_5 = 17'd20000;
   localparam logic [DG_CNT_W-1:0] DG_US_6 = 17'd50000;
   localparam logic [DG_CNT_W-1:0] DG_US_7 = 17'd100000;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_WAIT = 3'b010,
      ST_HOLD = 3'b100
   } ocfr_state_t;

   function automatic logic [DG_CNT_W-1:0] dg_limit_us(input logic [2:0] sel);
      logic [DG_CNT_W-1:0] lim;
      lim = '0;
      unique case (sel)
         3'b000: lim = '0;
         3'b001: lim = DG_US_1;
         3'b010: lim = DG_US_2;
         3'b011: lim = DG_US_3;
         3'b100: lim = DG_US_4;
         3'b101: lim = DG_US_5;
         3'b110: lim = DG_US_6;
         3'b111: lim = DG_US_7;
      endcase
      return lim;
   endfunction : dg_limit_us

   // Linear-11 word to whole milliseconds; negative values give zero, overflow saturates.
   function automatic logic [15:0] l11_to_ms(input logic [15:0] w);
      logic [4:0] e;
      logic [26:0] v;
      e = w[15:11];
      if (w[10]) begin
         v = '0;
      end else if (e[4]) begin
         v = {16'h0000, w[10:0]} >> (5'd0 - e);
      end else begin
         v = {16'h0000, w[10:0]} << e;
      end
      return (|v[26:16]) ? 16'hFFFF : v[15:0];
   endfunction : l11_to_ms

endpackage : ocfr_pkg

`default_nettype wire

// [hdl/ocfr_dg_if.sv]
// Purpose: Carrier between the top level and one deglitch filter.
// Assumes: All signals on clk_sys.
// Notes: hit is a one-cycle pulse per qualified fault episode.

`default_nettype none

interface ocfr_dg_if;
   logic us_tick;
   logic fault;
   logic [2:0] dly;
   logic hit;
   modport filt (input us_tick, input fault, input dly, output hit);
   modport user (output us_tick, output fault, output dly, input hit);
endinterface : ocfr_dg_if

`default_nettype wire

// [hdl/ocfr_tick.sv]
// Purpose: Microsecond and millisecond timebase.
// Assumes: TICK_CYC clocks make one microsecond.
// Notes: Ticks are one-cycle pulses, except that us_tick stays high when TICK_CYC is 1.

`default_nettype none

module ocfr_tick
   import ocfr_pkg::*;
#(
   parameter int TICK_CYC = US_TICK_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Timebase.
   output logic us_tick,
   output logic ms_tick
);
   localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   logic [PW-1:0] pre;
   logic [9:0] us_cnt;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pre <= '0;
         us_tick <= 1'b0;
      end else begin
         us_tick <= (pre == PW'(TICK_CYC - 1));
         pre <= (pre == PW'(TICK_CYC - 1)) ? '0 : pre + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         us_cnt <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= us_tick && (us_cnt == 10'(US_PER_MS - 1));
         if (us_tick) begin
            us_cnt <= (us_cnt == 10'(US_PER_MS - 1)) ? '0 : us_cnt + 1'b1;
         end
      end
   end

endmodule : ocfr_tick

`default_nettype wire

// [hdl/ocfr_deglitch.sv]
// Purpose: Deglitch filter for one fast supervisor fault line.
// Assumes: Fault line is already on clk_sys.
// Notes: Counts microsecond ticks while the fault stays present.

`default_nettype none

module ocfr_deglitch
   import ocfr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Filter side of the carrier.
   ocfr_dg_if.filt dg
);
   logic [DG_CNT_W-1:0] elapsed;
   logic [DG_CNT_W-1:0] limit;
   logic done;

   assign limit = dg_limit_us(dg.dly);

   // Any drop of the fault restarts the interval, so glitches shorter than the selected interval never qualify.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         elapsed <= '0;
      end else if (!dg.fault) begin
         elapsed <= '0;
      end else if (dg.us_tick && elapsed < limit) begin
         elapsed <= elapsed + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
         dg.hit <= 1'b0;
      end else begin
         dg.hit <= dg.fault && !done && (elapsed >= limit);
         done <= dg.fault && (done || elapsed >= limit);
      end
   end

endmodule : ocfr_deglitch

`default_nettype wire

// [hdl/ocfr_top.sv]
// Purpose: Output overcurrent and undercurrent fault response for four channels.
// Assumes: Commands come decoded, one per cmd_valid pulse; fault lines are on clk_sys.
// Notes: The sequencing engine performs turn-off waits; this block only requests them.

`default_nettype none

module ocfr_top
   import ocfr_pkg::*;
#(
   parameter int TICK_CYC = US_TICK_CYC,
   parameter logic [7:0] OC_RESP_RST = RST_RESP,
   parameter logic [7:0] UC_RESP_RST = RST_RESP
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Fast supervisor fault lines.
   input wire logic [NUM_CH-1:0] oc_detect,
   input wire logic [NUM_CH-1:0] uc_detect,
   // Channel control from the sequencing side.
   input wire logic [NUM_CH-1:0] chan_on_cmd,
   input wire logic [NUM_CH-1:0] track_en,
   input wire logic [NUM_CH-1:0] other_fault_off,
   output logic [NUM_CH-1:0] chan_enable,
   output logic [NUM_CH-1:0] off_now,
   output logic [NUM_CH-1:0] seq_off_req,
   output logic [NUM_CH-1:0] restart_req,
   // Decoded command port.
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [1:0] cmd_page,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_done,
   output logic cmd_unsup,
   output logic [15:0] cmd_rdata,
   // Open-drain alert line.
   output logic fault_alert_n_o,
   output logic fault_alert_n_oe
);

   // ********************************************************************
   // Parameter checks
   // ********************************************************************
   if (TICK_CYC < 1) begin : g_bad_tick
      $error("TICK_CYC must be at least one");
   end

   // ********************************************************************
   // Storage
   // ********************************************************************
   logic [7:0] oc_cfg [NUM_CH];
   logic [7:0] uc_cfg [NUM_CH];
   logic [7:0] oc_eff [NUM_CH];
   logic [7:0] uc_eff [NUM_CH];
   logic [7:0] flags [NUM_CH];
   logic [15:0] retry_delay;
   logic [7:0] retry_count;
   ocfr_state_t state [NUM_CH];
   logic [15:0] wait_ms [NUM_CH];
   logic [2:0] attempts [NUM_CH];
   logic [15:0] retry_ms;
   logic us_tick;
   logic ms_tick;
   logic [NUM_CH-1:0] hit_oc;
   logic [NUM_CH-1:0] hit_uc;
   logic [NUM_CH-1:0] shut_any;
   logic [2:0] shut_retry [NUM_CH];
   logic wr;
   logic clear;
   logic [7:0] sbyte;
   logic any_flag;

   assign wr = cmd_valid && cmd_write;
   assign clear = wr && (cmd_code == CMD_CLEAR_FAULTS);
   assign retry_ms = l11_to_ms(retry_delay);

   // ********************************************************************
   // Timebase and deglitch filters
   // ********************************************************************
   ocfr_tick #(
      .TICK_CYC(TICK_CYC)
   ) u_tick (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .us_tick(us_tick),
      .ms_tick(ms_tick)
   );

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      ocfr_dg_if dgo ();
      ocfr_dg_if dgu ();
      assign dgo.us_tick = us_tick;
      assign dgo.fault = oc_detect[g];
      assign dgo.dly = oc_eff[g][DLY_MSB:DLY_LSB];
      assign hit_oc[g] = dgo.hit;
      assign dgu.us_tick = us_tick;
      assign dgu.fault = uc_detect[g];
      assign dgu.dly = uc_eff[g][DLY_MSB:DLY_LSB];
      assign hit_uc[g] = dgu.hit;
      ocfr_deglitch u_dg_oc (
         .clk_sys(clk_sys),
         .nrst(nrst),
         .dg(dgo)
      );
      ocfr_deglitch u_dg_uc (
         .clk_sys(clk_sys),
         .nrst(nrst),
         .dg(dgu)
      );
   end

   // ********************************************************************
   // Response decision
   // ********************************************************************
   // Only the upper action bit calls for shutdown: 00b and 01b just report, and the
   // current itself is never limited by this block.
   always_comb begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
         shut_any[ch] = (hit_oc[ch] && oc_eff[ch][ACT_SHUT_BIT]) ||
                        (hit_uc[ch] && uc_eff[ch][ACT_SHUT_BIT]);
         shut_retry[ch] = (hit_oc[ch] && oc_eff[ch][ACT_SHUT_BIT]) ?
                          oc_eff[ch][RETRY_MSB:RETRY_LSB] :
                          uc_eff[ch][RETRY_MSB:RETRY_LSB];
      end
   end

   // ********************************************************************
   // Configuration
   // ********************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            oc_cfg[ch] <= OC_RESP_RST;
            uc_cfg[ch] <= UC_RESP_RST;
         end
         retry_delay <= RST_RETRY_DELAY;
         retry_count <= RST_RETRY_COUNT;
      end else if (wr) begin
         if (cmd_code == CMD_OC_RESP) begin
            oc_cfg[cmd_page] <= cmd_wdata[7:0];
         end
         if (cmd_code == CMD_UC_RESP) begin
            uc_cfg[cmd_page] <= cmd_wdata[7:0];
         end
         if (cmd_code == CMD_RETRY_DELAY) begin
            retry_delay <= cmd_wdata;
         end
         if (cmd_code == CMD_RETRY_COUNT) begin
            retry_count <= cmd_wdata[7:0];
         end
      end
   end

   // A running channel keeps the setting it started with; this avoids a half-applied
   // deglitch interval in the middle of a fault episode.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            oc_eff[ch] <= OC_RESP_RST;
            uc_eff[ch] <= UC_RESP_RST;
         end
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (!chan_on_cmd[ch]) begin
               oc_eff[ch] <= oc_cfg[ch];
               uc_eff[ch] <= uc_cfg[ch];
            end
         end
      end
   end

   // ********************************************************************
   // Shutdown and restart
   // ********************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            state[ch] <= ST_RUN;
            wait_ms[ch] <= '0;
            attempts[ch] <= '0;
         end
         chan_enable <= '0;
         off_now <= '0;
         seq_off_req <= '0;
         restart_req <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            off_now[ch] <= 1'b0;
            seq_off_req[ch] <= 1'b0;
            restart_req[ch] <= 1'b0;
            chan_enable[ch] <= chan_on_cmd[ch] && (state[ch] == ST_RUN);
            if (!chan_on_cmd[ch]) begin
               // Commanding the channel off clears the latched fault and the tally.
               state[ch] <= ST_RUN;
               attempts[ch] <= '0;
               wait_ms[ch] <= '0;
            end else begin
               unique case (state[ch])
                  ST_RUN: begin
                     if (shut_any[ch]) begin
                        chan_enable[ch] <= 1'b0;
                        if (track_en[ch]) begin
                           seq_off_req[ch] <= 1'b1;
                        end else begin
                           off_now[ch] <= 1'b1;
                        end
                        wait_ms[ch] <= '0;
                        if (shut_retry[ch] == 3'b000 ||
                            attempts[ch] >= retry_count[CNT_MSB:0]) begin
                           state[ch] <= ST_HOLD;
                        end else begin
                           state[ch] <= ST_WAIT;
                        end
                     end
                  end
                  ST_WAIT: begin
                     if (other_fault_off[ch]) begin
                        state[ch] <= ST_HOLD;
                     end else if (wait_ms[ch] >= retry_ms) begin
                        state[ch] <= ST_RUN;
                        attempts[ch] <= attempts[ch] + 1'b1;
                        restart_req[ch] <= 1'b1;
                        chan_enable[ch] <= 1'b1;
                     end else if (ms_tick) begin
                        wait_ms[ch] <= wait_ms[ch] + 1'b1;
                     end
                  end
                  ST_HOLD: begin
                     // Stays off; clearing status flags does not release it.
                     state[ch] <= ST_HOLD;
                  end
               endcase
            end
         end
      end
   end

   // ********************************************************************
   // Status flags and alert
   // ********************************************************************
   // A fault qualifying in the same cycle as a clear keeps its flag set.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            flags[ch] <= '0;
         end
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            flags[ch] <= '0;
            flags[ch][IOUT_OC_BIT] <= hit_oc[ch] || (flags[ch][IOUT_OC_BIT] && !clear);
            flags[ch][IOUT_UC_BIT] <= hit_uc[ch] || (flags[ch][IOUT_UC_BIT] && !clear);
         end
      end
   end

   always_comb begin
      any_flag = 1'b0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         any_flag = any_flag || (|flags[ch]);
      end
   end

   assign fault_alert_n_o = 1'b0;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fault_alert_n_oe <= 1'b0;
      end else begin
         fault_alert_n_oe <= any_flag;
      end
   end

   // ********************************************************************
   // Command read-back
   // ********************************************************************
   always_comb begin
      sbyte = '0;
      sbyte[SB_IOUT_OC_BIT] = flags[cmd_page][IOUT_OC_BIT];
      sbyte[SB_OTHER_BIT] = flags[cmd_page][IOUT_UC_BIT];
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_done <= 1'b0;
         cmd_unsup <= 1'b0;
         cmd_rdata <= '0;
      end else begin
         cmd_done <= cmd_valid;
         cmd_unsup <= 1'b0;
         if (cmd_valid) begin
            cmd_rdata <= '0;
            unique case (cmd_code)
               CMD_CLEAR_FAULTS: cmd_unsup <= !cmd_write;
               CMD_OC_RESP: cmd_rdata <= {8'h00, oc_cfg[cmd_page]};
               CMD_UC_RESP: cmd_rdata <= {8'h00, uc_cfg[cmd_page]};
               CMD_RETRY_DELAY: cmd_rdata <= retry_delay;
               CMD_RETRY_COUNT: cmd_rdata <= {8'h00, retry_count};
               CMD_STATUS_BYTE: begin
                  cmd_rdata <= {8'h00, sbyte};
                  cmd_unsup <= cmd_write;
               end
               CMD_STATUS_WORD: begin
                  cmd_rdata <= {8'h00, sbyte};
                  cmd_rdata[SW_IOUT_BIT] <= |flags[cmd_page];
                  cmd_unsup <= cmd_write;
               end
               CMD_OUTPUT_CURRENT_FLAGS: begin
                  cmd_rdata <= {8'h00, flags[cmd_page]};
                  cmd_unsup <= cmd_write;
               end
               default: cmd_unsup <= 1'b1;
            endcase
         end
      end
   end

endmodule : ocfr_top

`default_nettype wire

// [test/ocfr_supply_model.sv]
// Purpose: Supervisor and supplies as seen by the fault response block.
// Assumes: Faults are injected by the bench per channel.
// Notes: A disabled channel draws no current, so its fault lines go quiet.

`default_nettype none

module ocfr_supply_model
   import ocfr_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Channel state and injected faults.
   input wire logic [NUM_CH-1:0] chan_enable,
   input wire logic [NUM_CH-1:0] inj_oc,
   input wire logic [NUM_CH-1:0] inj_uc,
   // Fast supervisor lines.
   output logic [NUM_CH-1:0] oc_detect,
   output logic [NUM_CH-1:0] uc_detect
);
   timeunit 1ns;
   timeprecision 100ps;

   always_ff @(posedge clk_sys) begin
      oc_detect <= inj_oc & chan_enable;
      uc_detect <= inj_uc & chan_enable;
   end
endmodule : ocfr_supply_model

`default_nettype wire

// [test/ocfr_props.sv]
// Purpose: Port-level checks of the fault response block.
// Assumes: One clock domain.
// Notes: Bound to the top module.

`default_nettype none

module ocfr_props
   import ocfr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Channel side.
   input wire logic [NUM_CH-1:0] chan_on_cmd,
   input wire logic [NUM_CH-1:0] track_en,
   input wire logic [NUM_CH-1:0] chan_enable,
   input wire logic [NUM_CH-1:0] off_now,
   input wire logic [NUM_CH-1:0] seq_off_req,
   input wire logic [NUM_CH-1:0] restart_req,
   // Command port.
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_done,
   input wire logic cmd_unsup,
   // Alert.
   input wire logic fault_alert_n_o,
   input wire logic fault_alert_n_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence take_s;
      cmd_valid;
   endsequence
   sequence answer_s;
      ##1 cmd_done;
   endsequence
   sequence cut_s;
      (off_now | seq_off_req) != '0;
   endsequence

   done_follows_a: assert property (take_s |-> answer_s)
      else $error("no answer to command");
   done_cause_a: assert property (cmd_done |-> $past(cmd_valid))
      else $error("answer without command");
   clear_read_a: assert property (take_s ##0 (!cmd_write && cmd_code == CMD_CLEAR_FAULTS)
      |-> ##1 cmd_unsup)
      else $error("clear read not refused");
   alert_cut_a: assert property (cut_s |-> ##[1:2] fault_alert_n_oe)
      else $error("alert missing after shutdown");
   alert_level_a: assert property (fault_alert_n_oe |-> !fault_alert_n_o)
      else $error("alert drives high");
   cut_drops_a: assert property (cut_s |-> ((off_now | seq_off_req) & chan_enable) == '0)
      else $error("channel runs at shutdown");
   track_route_a: assert property ((off_now & track_en) == '0
      && (seq_off_req & ~track_en) == '0)
      else $error("shutdown took wrong route");
   restart_on_a: assert property ((restart_req & ~chan_enable) == '0)
      else $error("restart without enable");
   cmd_off_a: assert property (1'b1 |=> ((~$past(chan_on_cmd)) & chan_enable) == '0)
      else $error("enabled while commanded off");
endmodule : ocfr_props

`default_nettype wire

// [test/tb.sv]
// Purpose: Self-checking bench of the fault response block.
// Assumes: TICK_CYC of 1, so a microsecond is one clock.
// Notes: Command answers are checked from a queue of notes.

`default_nettype none

module tb
   import ocfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] chan_on_cmd = '0;
   logic [3:0] track_en = '0;
   logic [3:0] inj_oc = '0;
   logic [3:0] inj_uc = '0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [1:0] cmd_page = '0;
   logic [7:0] cmd_code = '0;
   logic [15:0] cmd_wdata = '0;
   logic [3:0] other_off = '0;
   logic [3:0] oc_detect, uc_detect, chan_enable, off_now, seq_off_req;
   logic cmd_done, cmd_unsup, alert_o, alert_oe;
   logic [15:0] cmd_rdata;
   logic [17:0] expq[$];
   logic [17:0] note;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;

   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   ocfr_top #(.TICK_CYC(1)) uut (.clk_sys(clk_sys), .nrst(nrst), .oc_detect(oc_detect),
      .uc_detect(uc_detect), .chan_on_cmd(chan_on_cmd), .track_en(track_en),
      .other_fault_off(other_off), .chan_enable(chan_enable), .off_now(off_now),
      .seq_off_req(seq_off_req), .restart_req(), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_unsup(cmd_unsup),
      .cmd_rdata(cmd_rdata), .fault_alert_n_o(alert_o), .fault_alert_n_oe(alert_oe));

   ocfr_supply_model u_sup (.clk_sys(clk_sys), .chan_enable(chan_enable), .inj_oc(inj_oc),
      .inj_uc(inj_uc), .oc_detect(oc_detect), .uc_detect(uc_detect));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic chk(input string nm, input logic ok);
      check(nm, {17'h0_0000, ok}, 18'h0_0001);
   endtask : chk

   // Reads note their data; a refused command notes only the refusal.
   task automatic cmd(input logic w, input logic [1:0] pg, input logic [7:0] cd,
      input logic [15:0] wd, input logic u, input logic [15:0] ex);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_page <= pg;
      cmd_code <= cd;
      cmd_wdata <= wd;
      expq.push_back({!w && !u, u, ex});
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask : cmd

   task automatic wait_en(input int ch, input logic lvl, input int lim, output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (chan_enable[ch] !== lvl && n < lim);
   endtask : wait_en

   task automatic results;
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   always @(posedge clk_sys) begin
      if (cmd_done === 1'b1) begin
         note = expq.pop_front();
         check("cmd_unsup", {17'h0_0000, cmd_unsup}, {17'h0_0000, note[16]});
         if (note[17]) begin
            check("cmd_rdata", {2'b00, cmd_rdata}, {2'b00, note[15:0]});
         end
      end
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   initial begin
      int n;
      logic [31:0] r;
      r = 32'h0000_37b9;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      cmd(0, 0, CMD_RETRY_COUNT, 0, 0, {8'h00, RST_RETRY_COUNT});
      cmd(0, 0, CMD_RETRY_DELAY, 0, 0, RST_RETRY_DELAY);
      cmd(0, 2, CMD_OC_RESP, 0, 0, {8'h00, RST_RESP});
      cmd(0, 0, CMD_CLEAR_FAULTS, 0, 1, 0);
      for (int p = 0; p < 4; p++) begin
         r = lfsr(r);
         cmd(1, p[1:0], CMD_UC_RESP, {8'h00, r[7:0]}, 0, 0);
         cmd(0, p[1:0], CMD_UC_RESP, 0, 0, {8'h00, r[7:0]});
      end
      cmd(1, 0, CMD_OC_RESP, 16'h00C8, 0, 0);
      cmd(1, 1, CMD_UC_RESP, 16'h0040, 0, 0);
      cmd(1, 2, CMD_OC_RESP, 16'h0081, 0, 0);
      cmd(1, 3, CMD_OC_RESP, 16'h00C0, 0, 0);
      cmd(1, 0, CMD_RETRY_DELAY, 16'h0002, 0, 0);
      cmd(1, 0, CMD_RETRY_COUNT, 16'h0001, 0, 0);
      track_en <= 4'h8;
      chan_on_cmd <= 4'hF;
      wait_en(3, 1, 5, n);
      @(posedge clk_sys);
      inj_oc <= 4'h1;
      wait_en(0, 0, 6, n);
      chk("instant cut", n <= 5);
      @(posedge clk_sys);
      inj_oc <= 4'h0;
      @(negedge clk_sys);
      chk("alert", alert_oe === 1'b1);
      cmd(0, 0, CMD_OUTPUT_CURRENT_FLAGS, 0, 0, 16'h0080);
      cmd(0, 0, CMD_STATUS_BYTE, 0, 0, 16'h0010);
      cmd(0, 0, CMD_STATUS_WORD, 0, 0, 16'h4010);
      wait_en(0, 1, 2600, n);
      chk("retry spacing", n >= 900 && n < 2600);
      @(posedge clk_sys);
      inj_oc <= 4'h1;
      wait_en(0, 0, 6, n);
      @(posedge clk_sys);
      inj_oc <= 4'h0;
      wait_en(0, 1, 3000, n);
      chk("retry limit", chan_enable[0] === 1'b0);
      cmd(1, 0, CMD_CLEAR_FAULTS, 0, 0, 0);
      repeat (2) @(negedge clk_sys);
      chk("alert release", alert_oe === 1'b0 && chan_enable[0] === 1'b0);
      cmd(0, 0, CMD_OUTPUT_CURRENT_FLAGS, 0, 0, 16'h0000);
      chan_on_cmd <= 4'hE;
      repeat (2) @(posedge clk_sys);
      chan_on_cmd <= 4'hF;
      wait_en(0, 1, 4, n);
      chk("off then on", chan_enable[0] === 1'b1);
      @(posedge clk_sys);
      inj_uc <= 4'h2;
      repeat (20) @(negedge clk_sys);
      chk("keep running", chan_enable[1] === 1'b1);
      cmd(0, 1, CMD_OUTPUT_CURRENT_FLAGS, 0, 0, 16'h0010);
      cmd(0, 1, CMD_STATUS_BYTE, 0, 0, 16'h0001);
      inj_uc <= 4'h0;
      inj_oc <= 4'h4;
      repeat (50) @(posedge clk_sys);
      inj_oc <= 4'h0;
      cmd(0, 2, CMD_OUTPUT_CURRENT_FLAGS, 0, 0, 16'h0000);
      inj_oc <= 4'h4;
      wait_en(2, 0, 130, n);
      chk("deglitch span", n >= 98 && n <= 106);
      wait_en(2, 1, 2500, n);
      chk("no retry", chan_enable[2] === 1'b0);
      @(posedge clk_sys);
      inj_oc <= 4'h9;
      other_off <= 4'h1;
      wait_en(3, 0, 6, n);
      chk("tracked off", seq_off_req[3] === 1'b1 && off_now[3] === 1'b0);
      @(posedge clk_sys);
      inj_oc <= 4'h0;
      wait_en(0, 1, 2500, n);
      chk("retry stopped", chan_enable[0] === 1'b0);
      repeat (4) @(posedge clk_sys);
      results();
   end
endmodule : tb

bind ocfr_top ocfr_props u_props (.clk_sys, .nrst, .chan_on_cmd, .track_en, .chan_enable,
   .off_now, .seq_off_req, .restart_req, .cmd_valid, .cmd_write, .cmd_code, .cmd_done,
   .cmd_unsup, .fault_alert_n_o, .fault_alert_n_oe);

`default_nettype wire
